// >>> common/fcl_pkg.sv
/*
 * Constants, types and defaults shared by the flow-control credit loop.
 * Assumes one 25 MHz clock and credit counters that wrap modulo their width.
 */
package fcl_pkg;
    localparam int FCL_NCLS = 6;
    localparam int FCL_NTYPE = 3;
    localparam int FCL_CW = 12;
    localparam int FCL_DW = 32;
    localparam int FCL_FIFO_DEPTH = 32;

    localparam int FCL_CLK_MHZ = 25;
    localparam int FCL_UPD_TIMER_US = 30;
    localparam int FCL_UPD_TIMER_CYC = FCL_UPD_TIMER_US * FCL_CLK_MHZ;

    localparam logic [FCL_CW-1:0] FCL_HDR_PER_PKT = 12'h001;
    localparam logic [FCL_CW-1:0] FCL_MAX_PAYLOAD_CRED = 12'h010;
    localparam int FCL_QUARTER_SHIFT = 2;

    // class index = type * 2 + (0 header, 1 data)
    localparam logic [FCL_CW-1:0] FCL_RX_CRED_DEF [FCL_NCLS] = '{12'h010, 12'h100, 12'h010, 12'h010, 12'h020, 12'h200};
    localparam logic [FCL_CW-1:0] FCL_STARVE_THR_DEF [FCL_NCLS] = '{FCL_HDR_PER_PKT, FCL_MAX_PAYLOAD_CRED,
        FCL_HDR_PER_PKT, FCL_MAX_PAYLOAD_CRED, FCL_HDR_PER_PKT, FCL_MAX_PAYLOAD_CRED};

    typedef enum logic [1:0] {FCL_P, FCL_NP, FCL_CPL} fcl_type_t;
    typedef enum logic [2:0] {FCL_PICK_NONE, FCL_PICK_FCH, FCL_PICK_TLP, FCL_PICK_DLLP, FCL_PICK_FCL} fcl_pick_t;
endpackage : fcl_pkg

// >>> common/fcl_stream_if.sv
/*
 * Valid/ready word stream between the credit loop and its receive buffer.
 * Assumes both ends on clk_sys.
 */
`timescale 1ns/100ps
interface fcl_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface : fcl_stream_if

// >>> src/fcl_credit_loop.sv
/*
 * Credit-based flow-control loop: transmit gating, receive buffer, credit
 * return and flow-control update scheduling onto the outgoing link.
 * Assumes link-side and application-side logic on clk_sys; link_busy is high
 * while a packet is on the outgoing link.
 */
`timescale 1ns/100ps
module fcl_credit_loop
    import fcl_pkg::*;
#(
    parameter int DW = FCL_DW,
    parameter int CW = FCL_CW,
    parameter int DEPTH = FCL_FIFO_DEPTH,
    parameter logic [FCL_CW-1:0] RX_CRED [FCL_NCLS] = FCL_RX_CRED_DEF,
    parameter logic [FCL_CW-1:0] STARVE_THR [FCL_NCLS] = FCL_STARVE_THR_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    // application transmit requests
    input wire logic tx_req,
    input wire fcl_type_t tx_type,
    input wire logic [CW-1:0] tx_dcred,
    output logic tx_grant,
    // other link-layer packets (acknowledgements)
    input wire logic dllp_req,
    output logic dllp_grant,
    input wire logic link_busy,
    // flow-control packets received from the far side
    input wire logic fc_in_init,
    input wire logic fc_in_upd,
    input wire fcl_type_t fc_in_type,
    input wire logic [CW-1:0] fc_in_hdr,
    input wire logic [CW-1:0] fc_in_data,
    // flow-control update to send
    output logic fc_out_valid,
    output logic fc_out_hipri,
    output fcl_type_t fc_out_type,
    output logic [CW-1:0] fc_out_hdr,
    output logic [CW-1:0] fc_out_data,
    // packets received from the link
    input wire logic rx_in_valid,
    output logic rx_in_ready,
    input wire logic [DW-1:0] rx_in_data,
    input wire logic rx_in_last,
    input wire fcl_type_t rx_in_type,
    input wire logic [CW-1:0] rx_in_dcred,
    // application receive side
    output logic app_valid,
    input wire logic app_ready,
    output logic [DW-1:0] app_data,
    output logic app_last,
    output fcl_type_t app_type,
    output logic [CW-1:0] app_dcred
);
    localparam int FW = DW + 1 + 2 + CW;
    localparam int TW = $clog2(FCL_UPD_TIMER_CYC + 1);
    localparam logic [TW-1:0] TMR_LOAD = TW'(FCL_UPD_TIMER_CYC);
    localparam logic [TW-1:0] TMR_LAST = TW'(1);

    if (DW < 1 || CW < 8 || FCL_UPD_TIMER_CYC < 2) begin : g_bad_param
        $error("fcl_credit_loop parameters out of range");
    end

    function automatic fcl_type_t first_type(input logic [FCL_NTYPE-1:0] v);
        if (v[0]) begin
            return FCL_P;
        end else if (v[1]) begin
            return FCL_NP;
        end
        return FCL_CPL;
    endfunction : first_type

    // transmit credit gate
    logic tx_ok;
    logic tx_take;

    fcl_tx_gate #(
        .CW(CW)
    ) u_gate (
        .clk_sys(clk_sys),
        .rst(rst),
        .lim_load(fc_in_init),
        .lim_upd(fc_in_upd),
        .lim_type(fc_in_type),
        .lim_hdr(fc_in_hdr),
        .lim_data(fc_in_data),
        .chk_type(tx_type),
        .chk_dcred(tx_dcred),
        .take(tx_take),
        .ok(tx_ok)
    );

    // receive buffer
    fcl_stream_if #(.W(FW)) fin ();
    fcl_stream_if #(.W(FW)) fout ();

    assign fin.valid = rx_in_valid;
    assign fin.data = {rx_in_data, rx_in_last, rx_in_type, rx_in_dcred};
    assign rx_in_ready = fin.ready;

    fcl_fifo #(
        .W(FW),
        .DEPTH(DEPTH)
    ) u_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr(fin.snk),
        .rd(fout.src)
    );

    // application output stage
    logic [DW-1:0] o_data;
    logic o_last;
    logic [1:0] o_type;
    logic [CW-1:0] o_dcred;
    logic stage_free;

    assign {o_data, o_last, o_type, o_dcred} = fout.data;
    assign stage_free = !app_valid || app_ready;
    assign fout.ready = stage_free;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            app_valid <= 1'b0;
            app_data <= '0;
            app_last <= 1'b0;
            app_type <= FCL_P;
            app_dcred <= '0;
        end else if (stage_free) begin
            app_valid <= fout.valid;
            if (fout.valid) begin
                app_data <= o_data;
                app_last <= o_last;
                app_type <= fcl_type_t'(o_type);
                app_dcred <= o_dcred;
            end
        end
    end

    // credit events
    logic rd_done;
    logic rx_done;
    assign rd_done = app_valid && app_ready && app_last;
    assign rx_done = rx_in_valid && rx_in_ready && rx_in_last;

    // arbitration picks
    fcl_pick_t pick;
    fcl_type_t pick_t;
    logic fc_pick;
    logic slot;
    logic hold;
    logic [FCL_NTYPE-1:0] pend;
    logic [FCL_NTYPE-1:0] hi;
    logic [FCL_NTYPE-1:0] force_upd;
    logic [TW-1:0] tmr;
    logic tmr_expire;

    // per-class receive counters
    logic [CW-1:0] alloc [FCL_NCLS];
    logic [CW-1:0] sent [FCL_NCLS];
    logic [FCL_NCLS-1:0] diff;
    logic [FCL_NCLS-1:0] starve;
    logic [FCL_NCLS-1:0] big;

    for (genvar c = 0; c < FCL_NCLS; c++) begin : g_rx
        localparam fcl_type_t CT = fcl_type_t'(c / 2);
        localparam bit IS_DATA = (c % 2) == 1;
        localparam logic [CW-1:0] QUARTER = CW'(RX_CRED[c] >> FCL_QUARTER_SHIFT);
        logic [CW-1:0] rcvd;
        logic [CW-1:0] rd_inc;
        logic [CW-1:0] rx_inc;
        logic [CW-1:0] remote_left;
        logic [CW-1:0] unsent;

        assign rd_inc = IS_DATA ? app_dcred : CW'(FCL_HDR_PER_PKT);
        assign rx_inc = IS_DATA ? rx_in_dcred : CW'(FCL_HDR_PER_PKT);

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                alloc[c] <= CW'(RX_CRED[c]);
            end else if (rd_done && app_type == CT) begin
                alloc[c] <= alloc[c] + rd_inc;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                rcvd <= '0;
            end else if (rx_done && rx_in_type == CT) begin
                rcvd <= rcvd + rx_inc;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                sent[c] <= CW'(RX_CRED[c]);
            end else if (fc_pick && pick_t == CT) begin
                sent[c] <= alloc[c];
            end
        end

        assign remote_left = sent[c] - rcvd;
        assign unsent = alloc[c] - sent[c];
        assign diff[c] = alloc[c] != sent[c];
        assign starve[c] = remote_left < CW'(STARVE_THR[c]) && diff[c];
        assign big[c] = unsent >= QUARTER && diff[c];
    end

    for (genvar t = 0; t < FCL_NTYPE; t++) begin : g_type
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                force_upd[t] <= 1'b0;
            end else if (tmr_expire) begin
                force_upd[t] <= 1'b1;
            end else if (fc_pick && pick_t == fcl_type_t'(t)) begin
                force_upd[t] <= 1'b0;
            end
        end

        assign pend[t] = diff[2*t] || diff[2*t+1] || force_upd[t];
        assign hi[t] = pend[t] && (starve[2*t] || starve[2*t+1] || big[2*t] || big[2*t+1] || force_upd[t]);
    end

    // update timer, reloaded on every update sent
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tmr <= TMR_LOAD;
        end else if (fc_pick) begin
            tmr <= TMR_LOAD;
        end else if (tmr != '0) begin
            tmr <= tmr - 1'b1;
        end
    end

    assign tmr_expire = tmr == TMR_LAST;

    // one pick per free link slot; the cycle after a pick waits for link_busy
    assign slot = !link_busy && !hold;

    always_comb begin
        pick = FCL_PICK_NONE;
        pick_t = FCL_P;
        if (slot) begin
            if (|hi) begin
                pick = FCL_PICK_FCH;
                pick_t = first_type(hi);
            end else if (tx_req && tx_ok) begin
                pick = FCL_PICK_TLP;
            end else if (dllp_req) begin
                pick = FCL_PICK_DLLP;
            end else if (|pend) begin
                pick = FCL_PICK_FCL;
                pick_t = first_type(pend);
            end
        end
    end

    assign fc_pick = pick == FCL_PICK_FCH || pick == FCL_PICK_FCL;
    assign tx_take = pick == FCL_PICK_TLP;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold <= 1'b0;
        end else begin
            hold <= pick != FCL_PICK_NONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_grant <= 1'b0;
            dllp_grant <= 1'b0;
            fc_out_valid <= 1'b0;
            fc_out_hipri <= 1'b0;
        end else begin
            tx_grant <= 1'b0;
            dllp_grant <= 1'b0;
            fc_out_valid <= 1'b0;
            fc_out_hipri <= 1'b0;
            unique case (pick)
                FCL_PICK_NONE: begin
                end
                FCL_PICK_FCH: begin
                    fc_out_valid <= 1'b1;
                    fc_out_hipri <= 1'b1;
                end
                FCL_PICK_TLP: begin
                    tx_grant <= 1'b1;
                end
                FCL_PICK_DLLP: begin
                    dllp_grant <= 1'b1;
                end
                FCL_PICK_FCL: begin
                    fc_out_valid <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fc_out_type <= FCL_P;
            fc_out_hdr <= '0;
            fc_out_data <= '0;
        end else if (fc_pick) begin
            fc_out_type <= pick_t;
            fc_out_hdr <= alloc[{pick_t, 1'b0}];
            fc_out_data <= alloc[{pick_t, 1'b1}];
        end
    end
endmodule : fcl_credit_loop

// >>> src/fcl_fifo.sv
/*
 * Receive buffer: synchronous FIFO, width and depth as parameters.
 * Assumes a power-of-two depth and a single clock with synchronous reset.
 */
`timescale 1ns/100ps
module fcl_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    fcl_stream_if.snk wr,
    fcl_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fcl_fifo depth must be a power of two of at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
    logic not_full;
    logic push;
    logic pop;
    logic [AW:0] next_cnt;

    assign push = wr.valid && not_full;
    assign pop = rd.ready && (cnt != '0);
    assign next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wptr] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
            not_full <= 1'b1;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
            cnt <= next_cnt;
            not_full <= next_cnt != FULL_CNT;
        end
    end

    assign wr.ready = not_full;
    assign rd.valid = cnt != '0;
    assign rd.data = mem[rptr];
endmodule : fcl_fifo

// >>> src/fcl_tx_gate.sv
/*
 * Transmit credit gate: limit and consumed counters for six classes.
 * Assumes chk_type and chk_dcred stay steady while a request waits.
 */
`timescale 1ns/100ps
module fcl_tx_gate
    import fcl_pkg::*;
#(
    parameter int CW = FCL_CW
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic lim_load,
    input wire logic lim_upd,
    input wire fcl_type_t lim_type,
    input wire logic [CW-1:0] lim_hdr,
    input wire logic [CW-1:0] lim_data,
    input wire fcl_type_t chk_type,
    input wire logic [CW-1:0] chk_dcred,
    input wire logic take,
    output logic ok
);
    if (CW < 8) begin : g_bad_cw
        $error("fcl_tx_gate credit width too small");
    end

    logic [FCL_NCLS-1:0] fit;

    for (genvar c = 0; c < FCL_NCLS; c++) begin : g_cls
        localparam fcl_type_t CT = fcl_type_t'(c / 2);
        localparam bit IS_DATA = (c % 2) == 1;
        logic [CW-1:0] lim;
        logic [CW-1:0] cons;
        logic [CW-1:0] avail;
        logic [CW-1:0] need;

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                lim <= '0;
            end else if ((lim_load || lim_upd) && lim_type == CT) begin
                lim <= IS_DATA ? lim_data : lim_hdr;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                cons <= '0;
            end else if (lim_load && lim_type == CT) begin
                cons <= '0;
            end else if (take && chk_type == CT) begin
                cons <= cons + need;
            end
        end

        assign need = IS_DATA ? chk_dcred : CW'(FCL_HDR_PER_PKT);
        assign avail = lim - cons;
        assign fit[c] = avail >= need;
    end

    assign ok = fit[{chk_type, 1'b0}] && fit[{chk_type, 1'b1}];
endmodule : fcl_tx_gate

// >>> tb/fcl_credit_loop_assertions.sv
/*
 * Port checks for fcl_credit_loop.
 * Assumes the bind below; one clock, synchronous reset.
 */
`timescale 1ns/100ps
module fcl_credit_loop_assertions #(
    parameter int CW = 12,
    parameter int DW = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tx_req,
    input wire logic tx_grant,
    input wire logic dllp_grant,
    input wire logic link_busy,
    input wire logic fc_in_init,
    input wire logic fc_out_valid,
    input wire logic fc_out_hipri,
    input wire logic [CW-1:0] fc_out_hdr,
    input wire logic [CW-1:0] fc_out_data,
    input wire logic app_valid,
    input wire logic app_ready,
    input wire logic [DW-1:0] app_data,
    input wire logic app_last
);
    logic pick;
    logic inited;
    logic [9:0] idle_cnt;
    assign pick = tx_grant | dllp_grant | fc_out_valid;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            inited <= 1'b0;
        end else if (fc_in_init) begin
            inited <= 1'b1;
        end
    end
    // idle link cycles since the last update went out
    always_ff @(posedge clk_sys) begin
        if (rst || fc_out_valid) begin
            idle_cnt <= 10'h000;
        end else if (!link_busy) begin
            idle_cnt <= idle_cnt + 10'h001;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_busy_holds_off: assert property (link_busy |=> !pick)
        else $error("pick while link busy");
    chk_pick_gap: assert property (pick |=> !pick)
        else $error("picks too close");
    chk_single_pick: assert property (tx_grant |-> !dllp_grant && !fc_out_valid)
        else $error("two picks at once");
    chk_hipri_valid: assert property (fc_out_hipri |-> fc_out_valid)
        else $error("priority flag without update");
    chk_grant_cause: assert property (tx_grant |-> $past(tx_req) && inited)
        else $error("grant without request or credit");
    chk_app_hold: assert property (app_valid && !app_ready |=> app_valid && $stable(app_data) && $stable(app_last))
        else $error("app word dropped");
    chk_update_hold: assert property (!fc_out_valid |-> $stable(fc_out_hdr) && $stable(fc_out_data))
        else $error("update values moved");
    chk_timer_bound: assert property (idle_cnt < 10'h302)
        else $error("no update after timer");
endmodule : fcl_credit_loop_assertions

bind fcl_credit_loop fcl_credit_loop_assertions #(.CW(CW), .DW(DW)) u_chk (.clk_sys, .rst, .tx_req, .tx_grant,
    .dllp_grant, .link_busy, .fc_in_init, .fc_out_valid, .fc_out_hipri, .fc_out_hdr, .fc_out_data,
    .app_valid, .app_ready, .app_data, .app_last);

// >>> tb/fcl_credit_loop_test.sv
/*
 * Self-checking bench for fcl_credit_loop with the link partner model.
 * Assumes the checker binds itself from its own file.
 */
`timescale 1ns/100ps
module fcl_credit_loop_test
    import fcl_pkg::*;
;
    logic clk_sys, rst, tx_req, tx_grant, dllp_req, dllp_grant, link_busy, fc_in_init, fc_in_upd;
    logic fc_out_valid, fc_out_hipri, rx_in_valid, rx_in_ready, rx_in_last, app_valid, app_ready, app_last;
    fcl_type_t tx_type, fc_in_type, fc_out_type, rx_in_type, app_type;
    logic [FCL_CW-1:0] tx_dcred, fc_in_hdr, fc_in_data, fc_out_hdr, fc_out_data, rx_in_dcred, app_dcred;
    logic [FCL_DW-1:0] rx_in_data, app_data;
    int errors;
    int check_count;
    fcl_credit_loop dut (.clk_sys, .rst, .tx_req, .tx_type, .tx_dcred, .tx_grant, .dllp_req, .dllp_grant,
        .link_busy, .fc_in_init, .fc_in_upd, .fc_in_type, .fc_in_hdr, .fc_in_data, .fc_out_valid,
        .fc_out_hipri, .fc_out_type, .fc_out_hdr, .fc_out_data, .rx_in_valid, .rx_in_ready, .rx_in_data,
        .rx_in_last, .rx_in_type, .rx_in_dcred, .app_valid, .app_ready, .app_data, .app_last, .app_type,
        .app_dcred);
    fcl_link_partner partner (.clk_sys, .tx_grant, .dllp_grant, .fc_out_valid, .link_busy, .fc_in_init,
        .fc_in_upd, .fc_in_type, .fc_in_hdr, .fc_in_data, .rx_in_valid, .rx_in_ready, .rx_in_data,
        .rx_in_last, .rx_in_type, .rx_in_dcred);
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    function automatic logic sig(input int k);
        return (k == 0) ? tx_grant : (k == 1) ? dllp_grant : fc_out_valid;
    endfunction : sig
    task automatic wait_for(input int k, input int lim, output int cyc);
        cyc = 0;
        do begin
            @(negedge clk_sys);
            cyc++;
        end while (sig(k) !== 1'b1 && cyc < lim);
    endtask : wait_for
    task automatic read_pkt(input int n, input fcl_type_t t, input logic [FCL_CW-1:0] dc);
        int i;
        int c;
        i = 0;
        c = 0;
        app_ready = 1'b1;
        // the word shown at this falling edge is taken at the next rising edge
        while (i < n && c < 400) begin
            if (app_valid === 1'b1) begin
                check(app_data === {16'h00a5, 16'(i)} && app_last === (i == n - 1), "word order");
                if (i == n - 1) begin
                    check(app_type === t && app_dcred === dc, "packet credits");
                end
                i++;
            end
            @(negedge clk_sys);
            c++;
        end
        check(i == n, "packet end");
        app_ready = 1'b0;
    endtask : read_pkt
    task automatic t_tx_gate();
        int c;
        @(negedge clk_sys);
        tx_type = FCL_P;
        tx_dcred = 12'h004;
        tx_req = 1'b1;
        wait_for(0, 20, c);
        check(tx_grant === 1'b0, "grant with no credit");
        partner.fc_send(1'b1, FCL_P, 12'h002, 12'h008);
        repeat (2) begin
            wait_for(0, 20, c);
            check(tx_grant === 1'b1, "no grant with credit");
        end
        wait_for(0, 30, c);
        check(tx_grant === 1'b0, "grant past header limit");
        partner.fc_send(1'b0, FCL_P, 12'h004, 12'h008);
        wait_for(0, 30, c);
        check(tx_grant === 1'b0, "grant past data limit");
        partner.fc_send(1'b0, FCL_P, 12'h004, 12'h00c);
        wait_for(0, 20, c);
        check(tx_grant === 1'b1, "update did not release");
        tx_req = 1'b0;
        for (int k = 1; k < 3; k++) begin
            partner.fc_send(1'b1, fcl_type_t'(k), 12'h001, 12'h000);
            tx_type = fcl_type_t'(k);
            tx_dcred = 12'h000;
            tx_req = 1'b1;
            wait_for(0, 20, c);
            check(tx_grant === 1'b1, "class grant");
            wait_for(0, 20, c);
            check(tx_grant === 1'b0, "class over limit");
            tx_req = 1'b0;
        end
    endtask : t_tx_gate
    task automatic t_rx_update();
        int c;
        dllp_req = 1'b1;
        wait_for(1, 10, c);
        check(dllp_grant === 1'b1, "no ack grant");
        partner.send_pkt(2, FCL_P, 12'h004);
        read_pkt(2, FCL_P, 12'h004);
        wait_for(2, 30, c);
        check(fc_out_valid === 1'b0, "update beat acknowledgements");
        dllp_req = 1'b0;
        wait_for(2, 20, c);
        check(fc_out_hipri === 1'b0 && fc_out_hdr === 12'h011 && fc_out_data === 12'h104, "update value");
    endtask : t_rx_update
    task automatic t_quarter();
        int c;
        logic [FCL_CW-1:0] ed;
        for (int k = 0; k < 2; k++) begin
            ed = (k == 1) ? 12'h183 : 12'h143;
            partner.send_pkt(1, FCL_P, 12'h03f + 12'(k));
            read_pkt(1, FCL_P, 12'h03f + 12'(k));
            wait_for(2, 20, c);
            check(fc_out_valid === 1'b1 && fc_out_hipri === 1'(k) && fc_out_data === ed, "quarter");
        end
    endtask : t_quarter
    task automatic t_starve();
        int c;
        // small packet then a large one: draining only the first leaves the sender short of data credits
        partner.send_pkt(1, FCL_CPL, 12'h001);
        partner.send_pkt(1, FCL_CPL, 12'h1f8);
        read_pkt(1, FCL_CPL, 12'h001);
        wait_for(2, 20, c);
        check(fc_out_hipri === 1'b1 && fc_out_type === FCL_CPL && fc_out_data === 12'h201, "starving sender");
        read_pkt(1, FCL_CPL, 12'h1f8);
        wait_for(2, 20, c);
        check(fc_out_hipri === 1'b1 && fc_out_hdr === 12'h022 && fc_out_data === 12'h3f9, "large return");
    endtask : t_starve
    task automatic t_fill();
        int c;
        fork
            partner.send_pkt(40, FCL_NP, 12'h000);
        join_none
        repeat (80) @(negedge clk_sys);
        check(rx_in_ready === 1'b0 && partner.accepted >= 32 && partner.accepted <= 33, "fill depth");
        read_pkt(40, FCL_NP, 12'h000);
        wait_for(2, 20, c);
        check(fc_out_type === FCL_NP && fc_out_hdr === 12'h011, "drain update");
    endtask : t_fill
    task automatic t_timer();
        int c;
        repeat (2) begin
            wait_for(2, 800, c);
            check(fc_out_hipri === 1'b1 && fc_out_type === FCL_P && c > 744 && c < 761, "timer");
            for (int k = 1; k < 3; k++) begin
                wait_for(2, 10, c);
                check(fc_out_hipri === 1'b1 && fc_out_type === fcl_type_t'(k), "forced update");
            end
        end
    endtask : t_timer
    initial begin
        errors = 0;
        check_count = 0;
        rst = 1'b1;
        tx_req = 1'b0;
        tx_type = FCL_P;
        tx_dcred = 12'h000;
        dllp_req = 1'b0;
        app_ready = 1'b0;
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        t_tx_gate();
        t_rx_update();
        t_quarter();
        t_starve();
        t_fill();
        t_timer();
        conclude();
    end
    initial begin
        #(40 * 20000);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule : fcl_credit_loop_test

// >>> tb/fcl_link_partner.sv
/*
 * Remote port model: holds the link after each pick, sends credit packets
 * and received-packet words. Assumes falling-edge driving.
 */
`timescale 1ns/100ps
module fcl_link_partner
    import fcl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic tx_grant,
    input wire logic dllp_grant,
    input wire logic fc_out_valid,
    output logic link_busy,
    output logic fc_in_init,
    output logic fc_in_upd,
    output fcl_type_t fc_in_type,
    output logic [FCL_CW-1:0] fc_in_hdr,
    output logic [FCL_CW-1:0] fc_in_data,
    output logic rx_in_valid,
    input wire logic rx_in_ready,
    output logic [FCL_DW-1:0] rx_in_data,
    output logic rx_in_last,
    output fcl_type_t rx_in_type,
    output logic [FCL_CW-1:0] rx_in_dcred
);
    logic [1:0] busy_left;
    int accepted;
    assign link_busy = tx_grant | dllp_grant | fc_out_valid | (busy_left != 2'h0);
    initial begin
        busy_left = 2'h0;
        fc_in_init = 1'b0;
        fc_in_upd = 1'b0;
        fc_in_type = FCL_P;
        fc_in_hdr = 12'h000;
        fc_in_data = 12'h000;
        rx_in_valid = 1'b0;
        rx_in_data = 32'h00000000;
        rx_in_last = 1'b0;
        rx_in_type = FCL_P;
        rx_in_dcred = 12'h000;
    end
    // a picked packet holds the link two more cycles
    always @(negedge clk_sys) begin
        if (tx_grant | dllp_grant | fc_out_valid)
            busy_left <= 2'h2;
        else if (busy_left != 2'h0)
            busy_left <= busy_left - 2'h1;
    end
    // init loads, later updates carry absolute limits
    task automatic fc_send(input logic init, input fcl_type_t t, input logic [FCL_CW-1:0] h,
        input logic [FCL_CW-1:0] d);
        @(negedge clk_sys);
        fc_in_init <= init;
        fc_in_upd <= ~init;
        fc_in_type <= t;
        fc_in_hdr <= h;
        fc_in_data <= d;
        @(negedge clk_sys);
        fc_in_init <= 1'b0;
        fc_in_upd <= 1'b0;
        fc_in_hdr <= ~h;
        fc_in_data <= ~d;
    endtask : fc_send
    task automatic send_pkt(input int n, input fcl_type_t t, input logic [FCL_CW-1:0] dc);
        int i;
        logic hit;
        i = 0;
        accepted = 0;
        @(negedge clk_sys);
        while (i < n) begin
            rx_in_valid <= 1'b1;
            rx_in_data <= {16'h00a5, 16'(i)};
            rx_in_last <= (i == n - 1);
            rx_in_type <= t;
            rx_in_dcred <= dc;
            hit = rx_in_ready;
            @(negedge clk_sys);
            if (hit === 1'b1) begin
                i++;
                accepted++;
            end
        end
        rx_in_valid <= 1'b0;
        rx_in_data <= ~rx_in_data;
    endtask : send_pkt
endmodule : fcl_link_partner
